// file: hdl/ibc_pkg.sv
// Package with constants for the ISA bus cycle control block.
package ibc_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] REG_CLOCK_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_SYS_CTRL_OFS   = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS     = 4'h8;
  localparam logic [3:0] REG_DMA_REQ_OFS    = 4'hC;
  // Clock control register fields.
  localparam int CLOCK_CONTROL_REGISTER_DIV_LSB = 0;
  localparam int CLOCK_CONTROL_REGISTER_SRC_BIT = 2;
  localparam logic [2:0] CLOCK_CONTROL_REGISTER_RESET = 3'h0;
  // System control port fields.
  localparam int SYS_IO_CHECK_EN_BIT = 3;
  localparam int SYS_CHAN_CHECK_BIT  = 6;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
  // Status register fields.
  localparam int STAT_AEN_BIT   = 0;
  localparam int STAT_BALE_BIT  = 1;
  localparam int STAT_NMI_BIT   = 2;
  localparam int STAT_STRAP_BIT = 3;
  localparam int STAT_BUSY_BIT  = 4;
  // Default wait states in bus clock periods; command delays in bus oscillator ticks.
  localparam logic [3:0] WS_CPU_8BIT  = 4'h4;
  localparam logic [3:0] WS_CPU_16BIT = 4'h1;
  localparam logic [3:0] WS_CPU_ROM   = 4'h3;
  localparam logic [3:0] WS_DMA       = 4'h1;
  localparam logic [3:0] CMD_DELAY_ONE = 4'h1;
  localparam logic [3:0] CMD_DELAY_TWO = 4'h2;
  // Cycle kinds requested by the internal sources.
  localparam logic [1:0] KIND_IO8  = 2'h0;
  localparam logic [1:0] KIND_IO16 = 2'h1;
  localparam logic [1:0] KIND_MEM  = 2'h2;
  localparam logic [1:0] KIND_ROM  = 2'h3;
  // Nominal bus oscillator and synchroniser depth.
  localparam int BUS_OSC_MHZ = 16;
  localparam int SYNC_STAGES = 2;
endpackage : ibc_pkg

// file: hdl/ibc_sync.sv
// Two-stage level synchroniser for one asynchronous input.
`timescale 1ns/100ps
module ibc_sync #(
  parameter int           STAGES    = 2,
  parameter logic         RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Data.
  input  wire logic       async_i,
  output logic            sync_o
);
  logic [STAGES-1:0] chain_r;

  // Only the last stage is read, so a metastable first stage never reaches logic.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      chain_r <= {STAGES{RESET_VAL}};
    else
      chain_r <= {chain_r[STAGES-2:0], async_i};
  end

  assign sync_o = chain_r[STAGES-1];
endmodule : ibc_sync

// file: hdl/ibc_clkdiv.sv
// Programmable divider producing the bus clock from the bus oscillator sample.
`timescale 1ns/100ps
module ibc_clkdiv (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Control.
  input  wire logic [1:0] div_sel_i,
  input  wire logic       osc_tick_i,
  // Output.
  output logic            sysclk_o,
  output logic            fall_o
);
  logic [2:0] cnt_r;
  logic [2:0] half_w;

  // Select 0..3 gives divide by 2, 4, 6 and 8; half period is sel plus one.
  assign half_w = {1'b0, div_sel_i} + 3'h1;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r    <= 3'h0;
      sysclk_o <= 1'b0;
      fall_o   <= 1'b0;
    end
    else
    begin
      fall_o <= 1'b0;
      if (osc_tick_i)
      begin
        if (cnt_r + 3'h1 >= half_w)
        begin
          cnt_r    <= 3'h0;
          sysclk_o <= ~sysclk_o;
          fall_o   <= sysclk_o;
        end
        else
          cnt_r <= cnt_r + 3'h1;
      end
    end
  end
endmodule : ibc_clkdiv

// file: hdl/ibc_top.sv
// ISA bus cycle control: address enables, bus clock, DMA inputs, channel check and wait states.
//
// Notes on behaviour
// - Address enable high only while DMA owns bus: hold ack high, master high.
// - Latch enable pulses high at the start of every CPU bus cycle.
// - Latch enable stays high whenever hold acknowledge is high.
// - Bus operations are timed from the bus oscillator input, nominally 16 MHz.
// - Bus clock is the oscillator divided by 2, 4, 6 or 8.
// - With CPU clock source, static oscillator level plus clock control selects divider.
// - Decode enable lets an external 3-to-8 decoder form acknowledges from code pins.
// - Local bus cycle during DMA uses decode enable to latch acknowledges externally.
// - Decode enable polarity follows the flush strap level caught at reset.
// - Asynchronous DMA requests: channels 0-3 for 8-bit, 5-7 for 16-bit.
// - Request channel 4 is internal cascade and never taken from outside.
// - Channel check low with check enable bit 3 clear raises NMI.
// - CPU default waits: four for 8-bit, one for 16-bit, three for ROM.
// - Every DMA transfer cycle gets one default wait state.
// - Ready is only pulled low or released, never driven high.
// - 16-bit I/O with IOCS16 high: convert to 8-bit, extra delay, four waits.
// - 16-bit I/O with IOCS16 low: one wait, one command delay, no conversion.
`timescale 1ns/100ps
module ibc_top (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Bus ownership and internal cycle requests.
  input  wire logic        hold_ack_i,
  input  wire logic        master_n_i,
  input  wire logic        cpu_cycle_req_i,
  input  wire logic [1:0]  cpu_cycle_kind_i,
  input  wire logic        dma_cycle_req_i,
  input  wire logic        local_cycle_i,
  input  wire logic [2:0]  dma_ack_code_i,
  // Bus pins.
  input  wire logic        bus_oscillator_in_i,
  input  wire logic        flush_strap_i,
  input  wire logic [7:0]  dma_req_i,
  input  wire logic        io_chan_check_n_i,
  input  wire logic        io_ready_i,
  input  wire logic        iocs16_n_i,
  output logic             aen_o,
  output logic             bale_o,
  output logic             sysclk_o,
  output logic             dma_ack_decode_enable_o,
  output logic             io_ready_o,
  output logic             io_ready_oe_n_o,
  output logic             nmi_o,
  output logic [7:0]       dma_req_sync_o,
  output logic             cycle_done_o,
  output logic             cycle_split_o
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    IBC_IDLE  = 4'b0001,
    IBC_DELAY = 4'b0010,
    IBC_WAIT  = 4'b0100,
    IBC_READY = 4'b1000
  } ibc_state_e;

  ibc_state_e  state_r;
  logic [2:0]  clock_control_register_r;
  logic [7:0]  sys_ctrl_r;
  logic        strap_r;
  logic        rst_seen_r;
  logic [3:0]  delay_r;
  logic [3:0]  wait_r;
  logic        is_dma_r;
  logic        osc_q_r;
  logic        osc_tick_w;
  logic        sysclk_w;
  logic        fall_w;
  logic [1:0]  div_sel_w;
  logic [7:0]  drq_w;
  logic        chk_n_w;
  logic        rdy_w;
  logic        iocs16_n_w;
  logic        dma_own_w;
  logic        dk_active_w;
  logic        bus_busy_w;

  //////////////////////////////////////////////////////////////////////////////
  // Inputs that arrive asynchronously are synchronised before any use.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_drq
      if (g == 4)
      begin : g_cascade
        assign drq_w[g] = 1'b0;
      end
      else
      begin : g_pin
        ibc_sync #(.STAGES(ibc_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_sync (
          .core_clk_i (core_clk_i),
          .rst_i      (rst_i),
          .async_i    (dma_req_i[g]),
          .sync_o     (drq_w[g])
        );
      end
    end
  endgenerate

  ibc_sync #(.STAGES(ibc_pkg::SYNC_STAGES), .RESET_VAL(1'b1)) u_chk_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (io_chan_check_n_i),
    .sync_o     (chk_n_w)
  );

  ibc_sync #(.STAGES(ibc_pkg::SYNC_STAGES), .RESET_VAL(1'b1)) u_rdy_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (io_ready_i),
    .sync_o     (rdy_w)
  );

  ibc_sync #(.STAGES(ibc_pkg::SYNC_STAGES), .RESET_VAL(1'b1)) u_cs_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (iocs16_n_i),
    .sync_o     (iocs16_n_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus clock from the bus oscillator; a stalled oscillator pin stands for a static level.
  logic osc_sync_w;
  ibc_sync #(.STAGES(ibc_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_osc_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (bus_oscillator_in_i),
    .sync_o     (osc_sync_w)
  );

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      osc_q_r <= 1'b0;
    else
      osc_q_r <= osc_sync_w;
  end

  // With the CPU clock as source, ticks come every core clock and the oscillator level with clock control bit 1 picks the ratio.
  assign osc_tick_w = clock_control_register_r[ibc_pkg::CLOCK_CONTROL_REGISTER_SRC_BIT] ? 1'b1
                    : (osc_sync_w & ~osc_q_r);
  assign div_sel_w  = clock_control_register_r[ibc_pkg::CLOCK_CONTROL_REGISTER_SRC_BIT]
                    ? {clock_control_register_r[ibc_pkg::CLOCK_CONTROL_REGISTER_DIV_LSB + 1], osc_sync_w}
                    : clock_control_register_r[ibc_pkg::CLOCK_CONTROL_REGISTER_DIV_LSB +: 2];

  ibc_clkdiv u_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .div_sel_i  (div_sel_w),
    .osc_tick_i (osc_tick_w),
    .sysclk_o   (sysclk_w),
    .fall_o     (fall_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Strap is caught by a clocked process on the first edge after reset release.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_r    <= 1'b1;
      rst_seen_r <= 1'b0;
    end
    else if (!rst_seen_r)
    begin
      strap_r    <= flush_strap_i;
      rst_seen_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle timer: command delay, then wait states counted on bus clock falls.
  assign bus_busy_w = (state_r != IBC_IDLE);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r       <= IBC_IDLE;
      delay_r       <= 4'h0;
      wait_r        <= 4'h0;
      is_dma_r      <= 1'b0;
      cycle_done_o  <= 1'b0;
      cycle_split_o <= 1'b0;
    end
    else
    begin
      cycle_done_o <= 1'b0;
      case (state_r)
        IBC_IDLE:
        begin
          if (dma_cycle_req_i && dma_own_w && !cycle_done_o)
          begin
            is_dma_r      <= 1'b1;
            delay_r       <= ibc_pkg::CMD_DELAY_ONE;
            wait_r        <= ibc_pkg::WS_DMA;
            cycle_split_o <= 1'b0;
            state_r       <= IBC_DELAY;
          end
          else if (cpu_cycle_req_i && !hold_ack_i && !cycle_done_o)
          begin
            is_dma_r <= 1'b0;
            state_r  <= IBC_DELAY;
            case (cpu_cycle_kind_i)
              ibc_pkg::KIND_IO16:
              begin
                if (iocs16_n_w)
                begin
                  delay_r       <= ibc_pkg::CMD_DELAY_TWO;
                  wait_r        <= ibc_pkg::WS_CPU_8BIT;
                  cycle_split_o <= 1'b1;
                end
                else
                begin
                  delay_r       <= ibc_pkg::CMD_DELAY_ONE;
                  wait_r        <= ibc_pkg::WS_CPU_16BIT;
                  cycle_split_o <= 1'b0;
                end
              end
              ibc_pkg::KIND_MEM:
              begin
                delay_r       <= ibc_pkg::CMD_DELAY_ONE;
                wait_r        <= ibc_pkg::WS_CPU_16BIT;
                cycle_split_o <= 1'b0;
              end
              ibc_pkg::KIND_ROM:
              begin
                delay_r       <= ibc_pkg::CMD_DELAY_ONE;
                wait_r        <= ibc_pkg::WS_CPU_ROM;
                cycle_split_o <= 1'b0;
              end
              default:
              begin
                delay_r       <= ibc_pkg::CMD_DELAY_ONE;
                wait_r        <= ibc_pkg::WS_CPU_8BIT;
                cycle_split_o <= 1'b0;
              end
            endcase
          end
        end
        IBC_DELAY:
        begin
          if (osc_tick_w)
          begin
            if (delay_r <= 4'h1)
              state_r <= IBC_WAIT;
            delay_r <= delay_r - 4'h1;
          end
        end
        IBC_WAIT:
        begin
          if (fall_w)
          begin
            if (wait_r <= 4'h1)
              state_r <= IBC_READY;
            wait_r <= wait_r - 4'h1;
          end
        end
        IBC_READY:
        begin
          // A peripheral holding ready low stretches the cycle here.
          if (rdy_w)
          begin
            cycle_done_o <= 1'b1;
            state_r      <= IBC_IDLE;
          end
        end
        default:
          state_r <= IBC_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus control outputs.
  assign dma_own_w   = hold_ack_i && master_n_i;
  assign dk_active_w = (dma_own_w && (state_r == IBC_DELAY)) || (dma_own_w && local_cycle_i);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aen_o                   <= 1'b0;
      bale_o                  <= 1'b0;
      sysclk_o                <= 1'b0;
      dma_ack_decode_enable_o <= 1'b0;
      io_ready_o              <= 1'b0;
      io_ready_oe_n_o         <= 1'b1;
      nmi_o                   <= 1'b0;
      dma_req_sync_o          <= 8'h00;
    end
    else
    begin
      aen_o    <= dma_own_w;
      // Pulse on a newly taken CPU cycle; forced high throughout hold acknowledge.
      bale_o   <= hold_ack_i || (cpu_cycle_req_i && (state_r == IBC_IDLE) && !cycle_done_o);
      sysclk_o <= sysclk_w;
      // Codes on dma_ack_code_i are valid at DMA cycle start; external decoder also
      // keeps acknowledges latched across local bus cycles, which fences other I/O off.
      dma_ack_decode_enable_o <= strap_r ? dk_active_w : ~dk_active_w;
      // Only ever drives low; released otherwise.
      io_ready_o      <= 1'b0;
      io_ready_oe_n_o <= ~(is_dma_r && bus_busy_w && (state_r != IBC_READY));
      nmi_o           <= !chk_n_w && !sys_ctrl_r[ibc_pkg::SYS_IO_CHECK_EN_BIT];
      dma_req_sync_o  <= drq_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, answer on the second edge.
  logic pend_r;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_r                   <= 1'b0;
      avs_waitrequest_o        <= 1'b1;
      avs_readdata_o           <= 32'h0000_0000;
      clock_control_register_r <= ibc_pkg::CLOCK_CONTROL_REGISTER_RESET;
      sys_ctrl_r               <= ibc_pkg::SYS_CTRL_RESET;
    end
    else
    begin
      avs_waitrequest_o <= 1'b1;
      pend_r            <= 1'b0;
      if ((avs_read_i || avs_write_i) && !pend_r && avs_waitrequest_o)
      begin
        pend_r            <= 1'b1;
        avs_waitrequest_o <= 1'b0;
        if (avs_write_i)
        begin
          case (avs_address_i)
            ibc_pkg::REG_CLOCK_CTRL_OFS: clock_control_register_r <= avs_writedata_i[2:0];
            ibc_pkg::REG_SYS_CTRL_OFS:   sys_ctrl_r <= avs_writedata_i[7:0];
            default: ;
          endcase
          avs_readdata_o <= 32'h0000_0000;
        end
        else
        begin
          case (avs_address_i)
            ibc_pkg::REG_CLOCK_CTRL_OFS: avs_readdata_o <= {29'h0, clock_control_register_r};
            ibc_pkg::REG_SYS_CTRL_OFS:
              avs_readdata_o <= {24'h0, sys_ctrl_r[7], chk_n_w, sys_ctrl_r[5:0]};
            ibc_pkg::REG_STATUS_OFS:
              avs_readdata_o <= {27'h0, bus_busy_w, strap_r, nmi_o, bale_o, aen_o};
            ibc_pkg::REG_DMA_REQ_OFS: avs_readdata_o <= {24'h0, drq_w};
            default: avs_readdata_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule : ibc_top

// file: tb/ibc_top_props.sv
// Concurrent checks on the ports of the ISA bus cycle control block.
`timescale 1ns/100ps
module ibc_top_props (
  // Clock and reset.
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // Inputs of the block.
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       hold_ack_i,
  input wire logic       master_n_i,
  input wire logic       cpu_cycle_req_i,
  input wire logic [1:0] cpu_cycle_kind_i,
  input wire logic       flush_strap_i,
  input wire logic [7:0] dma_req_i,
  input wire logic       io_chan_check_n_i,
  input wire logic       io_ready_i,
  input wire logic       iocs16_n_i,
  // Outputs of the block.
  input wire logic       avs_waitrequest_o,
  input wire logic       aen_o,
  input wire logic       bale_o,
  input wire logic       dma_ack_decode_enable_o,
  input wire logic       io_ready_o,
  input wire logic       io_ready_oe_n_o,
  input wire logic       nmi_o,
  input wire logic [7:0] dma_req_sync_o,
  input wire logic       cycle_done_o,
  input wire logic       cycle_split_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cpu_start;
    $rose(cpu_cycle_req_i) && !hold_ack_i;
  endsequence
  sequence s_ready_low;
    !io_ready_i [*5];
  endsequence
  ////////////////////////////////////////
  a_aen_owner: assert property (hold_ack_i && master_n_i |=> aen_o)
    else $error("address enable missing while DMA owns the bus");
  a_aen_other: assert property (!(hold_ack_i && master_n_i) |=> !aen_o)
    else $error("address enable high without DMA ownership");
  a_bale_cpu: assert property (s_cpu_start |=> bale_o)
    else $error("latch enable missing at CPU cycle start");
  a_bale_hold: assert property (hold_ack_i |=> bale_o)
    else $error("latch enable low during hold acknowledge");
  a_decode_idle: assert property (!hold_ack_i [*4] |-> dma_ack_decode_enable_o == !flush_strap_i)
    else $error("decode enable not at its idle level");
  a_req_sync: assert property ($stable(dma_req_i) [*4] |-> dma_req_sync_o == (dma_req_i & 8'hEF))
    else $error("synchronised requests differ from inputs");
  a_nmi_clear: assert property (io_chan_check_n_i [*4] |=> !nmi_o)
    else $error("NMI without channel check");
  a_ready_stall: assert property (s_ready_low |-> !cycle_done_o)
    else $error("cycle ended while ready held low");
  a_ready_never_high: assert property (!(io_ready_o && !io_ready_oe_n_o))
    else $error("ready line driven high");
  a_split_kind: assert property (cycle_done_o && !hold_ack_i |->
    cycle_split_o == (cpu_cycle_kind_i == ibc_pkg::KIND_IO16 && iocs16_n_i))
    else $error("conversion flag wrong at cycle end");
  a_bus_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("register bus answer not one cycle long");
endmodule : ibc_top_props

bind ibc_top ibc_top_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .hold_ack_i(hold_ack_i), .master_n_i(master_n_i), .cpu_cycle_req_i(cpu_cycle_req_i),
  .cpu_cycle_kind_i(cpu_cycle_kind_i), .flush_strap_i(flush_strap_i), .dma_req_i(dma_req_i),
  .io_chan_check_n_i(io_chan_check_n_i), .io_ready_i(io_ready_i), .iocs16_n_i(iocs16_n_i),
  .avs_waitrequest_o(avs_waitrequest_o), .aen_o(aen_o), .bale_o(bale_o),
  .dma_ack_decode_enable_o(dma_ack_decode_enable_o), .io_ready_o(io_ready_o), .io_ready_oe_n_o(io_ready_oe_n_o),
  .nmi_o(nmi_o), .dma_req_sync_o(dma_req_sync_o), .cycle_done_o(cycle_done_o), .cycle_split_o(cycle_split_o));

// file: tb/ibc_isa_adapter.sv
// Behavioural ISA adapter on the far side of the block.
`timescale 1ns/100ps
module ibc_isa_adapter (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Bus pins seen by the adapter.
  input  wire logic       bale_i,
  input  wire logic       aen_i,
  input  wire logic       ready_oe_n_i,
  input  wire logic [2:0] ack_code_i,
  // Behaviour chosen by the bench.
  input  wire logic       slow_i,
  input  wire logic       wide_i,
  input  wire logic       fault_i,
  // Pins driven by the adapter.
  output logic            pull_low_o,
  output logic            iocs16_n_o,
  output logic            chan_check_n_o,
  output logic            osc_o
);
  localparam logic [2:0] OWN_CHANNEL = 3'h5;
  logic [6:0] stretch_r;
  logic       bale_d_r;
  logic       oe_n_d_r;
  initial osc_o = 1'h0;
  always #31.25 osc_o = ~osc_o;
  // A slow card stretches each cycle it answers; under DMA only the acknowledged card answers.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stretch_r <= 7'h00;
      bale_d_r  <= 1'h0;
      oe_n_d_r  <= 1'h1;
    end
    else
    begin
      bale_d_r <= bale_i;
      oe_n_d_r <= ready_oe_n_i;
      if (((bale_i && !bale_d_r) || (!ready_oe_n_i && oe_n_d_r)) && slow_i && (!aen_i || ack_code_i == OWN_CHANNEL))
        stretch_r <= 7'h40;
      else if (stretch_r != 7'h00)
        stretch_r <= stretch_r - 7'h01;
    end
  end
  assign pull_low_o     = stretch_r != 7'h00;
  assign iocs16_n_o     = !wide_i;
  assign chan_check_n_o = !fault_i;
endmodule : ibc_isa_adapter

// file: tb/isa_bus_cycle_control_tb_top.sv
// Self-checking bench for the ISA bus cycle control block.
`timescale 1ns/100ps
module isa_bus_cycle_control_tb_top;
  logic        core_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic        avs_waitrequest_o, hold_ack_i = 1'h0, master_n_i = 1'h1, cpu_cycle_req_i = 1'h0;
  logic [1:0]  cpu_cycle_kind_i = 2'h0;
  logic        dma_cycle_req_i = 1'h0, local_cycle_i = 1'h0, flush_strap_i = 1'h1;
  logic [2:0]  dma_ack_code_i = 3'h5;
  logic [7:0]  dma_req_i = 8'h00, dma_req_sync_o;
  logic        slow = 1'h0, wide = 1'h1, fault = 1'h0, osc, pull_low, iocs16_n, chan_check_n, io_ready_i;
  logic        aen_o, bale_o, sysclk_o, dack_en, io_ready_o, ready_oe_n, nmi_o, cycle_done_o, cycle_split_o, sys_d;
  int          n_errors = 0, n_compared = 0, n_io8, n_rom, n_mem, n_w16, n_n16, n_slow, n_fast, edges;
  // Open-drain ready line with its pull-up.
  assign io_ready_i = !pull_low && (ready_oe_n || io_ready_o);
  initial forever #10 core_clk_i = ~core_clk_i;
  ibc_top dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .hold_ack_i(hold_ack_i), .master_n_i(master_n_i),
    .cpu_cycle_req_i(cpu_cycle_req_i), .cpu_cycle_kind_i(cpu_cycle_kind_i), .dma_cycle_req_i(dma_cycle_req_i),
    .local_cycle_i(local_cycle_i), .dma_ack_code_i(dma_ack_code_i), .bus_oscillator_in_i(osc),
    .flush_strap_i(flush_strap_i), .dma_req_i(dma_req_i), .io_chan_check_n_i(chan_check_n),
    .io_ready_i(io_ready_i), .iocs16_n_i(iocs16_n), .aen_o(aen_o), .bale_o(bale_o), .sysclk_o(sysclk_o),
    .dma_ack_decode_enable_o(dack_en), .io_ready_o(io_ready_o), .io_ready_oe_n_o(ready_oe_n), .nmi_o(nmi_o),
    .dma_req_sync_o(dma_req_sync_o), .cycle_done_o(cycle_done_o), .cycle_split_o(cycle_split_o));
  ibc_isa_adapter card (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bale_i(bale_o), .aen_i(aen_o), .ready_oe_n_i(ready_oe_n),
    .ack_code_i(dma_ack_code_i), .slow_i(slow), .wide_i(wide), .fault_i(fault), .pull_low_o(pull_low),
    .iocs16_n_o(iocs16_n), .chan_check_n_o(chan_check_n), .osc_o(osc));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t ns: got %08h, expected %08h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("unexpected at %0t ns: got %0h, expected %0h to %0h", $time, got, lo, hi);
    end
  endtask : chk_cnt
  // Holds the request until waitrequest is seen low, then idles one cycle before any next request.
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int t;
    t = 0;
    avs_address_i <= adr;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
    begin
      @(posedge core_clk_i);
      t++;
    end
    while (avs_waitrequest_o !== 1'h0 && t < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    if (t >= 50)
      n_errors++;
    @(posedge core_clk_i);
  endtask : bus
  task automatic run_cycle(input logic dma, input logic [1:0] kind, output int cnt);
    cnt = 0;
    @(negedge sysclk_o);
    cpu_cycle_kind_i <= kind;
    dma_cycle_req_i <= dma;
    cpu_cycle_req_i <= !dma;
    do
    begin
      @(posedge core_clk_i);
      cnt++;
    end
    while (cycle_done_o !== 1'h1 && cnt < 2000);
    cpu_cycle_req_i <= 1'h0;
    dma_cycle_req_i <= 1'h0;
    if (cnt >= 2000)
      n_errors++;
    repeat (3) @(posedge core_clk_i);
  endtask : run_cycle
  ////////////////////////////////////////
  initial
  begin
    #1000000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge core_clk_i);
    bus(1'h0, ibc_pkg::REG_CLOCK_CTRL_OFS, 32'h0);
    chk(rd, {29'h0, ibc_pkg::CLOCK_CONTROL_REGISTER_RESET});
    bus(1'h0, ibc_pkg::REG_SYS_CTRL_OFS, 32'h0);
    chk(rd, {24'h0, ibc_pkg::SYS_CTRL_RESET} | 32'h40);
    bus(1'h0, ibc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd, 32'h8);
    bus(1'h0, 4'h1, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      bus(1'h1, ibc_pkg::REG_CLOCK_CTRL_OFS, s);
      repeat (30) @(posedge core_clk_i);
      edges = 0;
      repeat (150)
      begin
        @(posedge core_clk_i);
        sys_d = sysclk_o;
        #1;
        if (sysclk_o && !sys_d)
          edges++;
      end
      chk_cnt(edges, 48 / (2 * (s + 1)) - 1, 48 / (2 * (s + 1)) + 1);
    end
    bus(1'h1, ibc_pkg::REG_CLOCK_CTRL_OFS, 32'h0);
    $display("test divider done");
    dma_req_i <= 8'hFF;
    repeat (6) @(posedge core_clk_i);
    bus(1'h0, ibc_pkg::REG_DMA_REQ_OFS, 32'h0);
    chk(rd, 32'hEF);
    dma_req_i <= 8'h10;
    repeat (6) @(posedge core_clk_i);
    chk(dma_req_sync_o, 8'h00);
    $display("test requests done");
    fault <= 1'h1;
    repeat (6) @(posedge core_clk_i);
    chk(nmi_o, 1'h1);
    bus(1'h0, ibc_pkg::REG_SYS_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, ibc_pkg::REG_SYS_CTRL_OFS, 32'h8);
    repeat (3) @(posedge core_clk_i);
    chk(nmi_o, 1'h0);
    fault <= 1'h0;
    bus(1'h1, ibc_pkg::REG_SYS_CTRL_OFS, 32'h0);
    $display("test channel check done");
    run_cycle(1'h0, ibc_pkg::KIND_IO8, n_io8);
    run_cycle(1'h0, ibc_pkg::KIND_ROM, n_rom);
    run_cycle(1'h0, ibc_pkg::KIND_MEM, n_mem);
    run_cycle(1'h0, ibc_pkg::KIND_IO16, n_w16);
    chk(cycle_split_o, 1'h0);
    wide <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    run_cycle(1'h0, ibc_pkg::KIND_IO16, n_n16);
    chk(cycle_split_o, 1'h1);
    chk_cnt(n_io8, n_rom + 1, 2000);
    chk_cnt(n_rom, n_mem + 1, 2000);
    chk_cnt(n_w16, n_mem - 2, n_mem + 2);
    chk_cnt(n_n16, n_w16 + 1, 2000);
    slow <= 1'h1;
    run_cycle(1'h0, ibc_pkg::KIND_IO8, n_slow);
    chk_cnt(n_slow, n_io8 + 16, 2000);
    slow <= 1'h0;
    wide <= 1'h1;
    $display("test cpu cycles done");
    hold_ack_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    chk({aen_o, bale_o}, 2'h3);
    bus(1'h0, ibc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd, 32'hB);
    local_cycle_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    chk(dack_en, 1'h1);
    local_cycle_i <= 1'h0;
    run_cycle(1'h1, ibc_pkg::KIND_IO8, n_fast);
    chk_cnt(n_fast, 2, 2000);
    slow <= 1'h1;
    run_cycle(1'h1, ibc_pkg::KIND_IO8, n_slow);
    chk_cnt(n_slow, n_fast + 16, 2000);
    slow <= 1'h0;
    master_n_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    chk({aen_o, bale_o}, 2'h1);
    hold_ack_i <= 1'h0;
    master_n_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    flush_strap_i <= 1'h0;
    rst_i <= 1'h1;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge core_clk_i);
    chk(dack_en, 1'h1);
    $display("test dma done");
    complete_run();
  end
endmodule : isa_bus_cycle_control_tb_top
